/* File: src/serial_rx_pkg.sv */
// Summary of operation
// - data recovery samples at sixteen times baud; shift register advances once per bit
// - completed 8 or 9 bit character moves at once into hidden two-entry fifo
// - while port enabled, transmit pin is always driven as output
// - falling edge, wait half bit, recheck low; else drop silently and rearm
// - step full bit to each centre, majority vote, shift into shift register
// - one more bit is stop; low marks framing error for that character
// - after stop push character, raise flag; each data read pops oldest
// - polarity bit default 0 idle-high; 1 inverts incoming line
// - receive flag high exactly while enabled and fifo holds unread character
// - flag always raised; interrupt only when all three enables set
// - framing bit stored per entry; status shows oldest unread entry
// - framing error does not stop reception; pop shows next entry's bit
// - port disable resets and clears framing; receive disable keeps it; no irq
// - third character with fifo full sets overrun, keeps data, blocks reception
// - overrun cleared only by clearing receive enable or port enable
// - nine-bit mode shifts 9 bits; ninth bit of oldest entry readable as status
// - address detect with nine-bit keeps only characters whose ninth bit set
package serial_rx_pkg;

  // -------------------------------------------------------------------
  // register map (word index = byte address on this port)
  // -------------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;  // enables and modes
  localparam logic [3:0] ADDR_STATUS  = 4'h1;  // ninth and framing bits of oldest entry, plus overrun, flag, idle
  localparam logic [3:0] ADDR_DATA    = 4'h2;  // receive data register, pops

  // control field positions
  localparam int CTL_PORT_EN   = 0;
  localparam int CTL_RX_EN     = 1;
  localparam int CTL_NINE_BIT  = 2;
  localparam int CTL_ADDR_DET  = 3;
  localparam int CTL_POLARITY  = 4;
  localparam int CTL_SYNC_MODE = 5;
  localparam int CTL_RX_IE     = 6;
  localparam int CTL_PERIPH_IE = 7;
  localparam int CTL_GLOBAL_IE = 8;
  localparam int CTL_WIDTH     = 9;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 9'h000;

  // status field positions
  localparam int STA_NINTH   = 0;
  localparam int STA_OVERRUN = 1;
  localparam int STA_FRAMING = 2;
  localparam int STA_FLAG    = 3;
  localparam int STA_IDLE    = 4;

  // oversampling timing, in baud ticks
  localparam logic [3:0] TICKS_PER_BIT  = 4'hF;  // last tick index of a bit
  localparam logic [3:0] TICKS_HALF_BIT = 4'h7;  // eighth tick reaches mid-start
  localparam logic [3:0] VOTE_FIRST     = 4'h6;  // three samples around centre
  localparam logic [3:0] VOTE_LAST      = 4'h8;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage : serial_rx_pkg

/* File: src/serial_rx_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_rx_sync
(
  input  wire logic clock,  // peripheral clock
  input  wire logic rst,    // synchronous, active high
  input  wire logic ce,     // clock enable
  input  wire logic din,    // asynchronous level
  output logic      dout    // synchronised level
);
  typedef struct packed {logic s1; logic s2;} sync_state_t;
  sync_state_t st;
  sync_state_t next_st;

  // ---------------------------------------------------------------
  // two-stage synchroniser, idles high to match a quiet line
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      st <= 2'b11;
    else if (ce)
      st <= next_st;
  end

  assign dout = st.s2;
endmodule : serial_rx_sync
`default_nettype wire

/* File: src/serial_rx_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_rx_fifo #(
  parameter int WIDTH = 10,  // 9 data bits plus framing bit
  parameter int DEPTH = 2
)
(
  input  wire logic             clock,  // peripheral clock
  input  wire logic             rst,    // synchronous flush
  input  wire logic             ce,     // clock enable
  input  wire logic             push,   // write one entry
  input  wire logic [WIDTH-1:0] wdata,  // entry to write
  input  wire logic             pop,    // drop oldest entry
  output logic      [WIDTH-1:0] rdata,  // oldest entry
  output logic                  empty,  // nothing stored
  output logic                  full    // depth entries stored
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH != 2 ** AW || WIDTH < 1)
      $error("serial_rx_fifo: depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
  } fifo_state_t;
  fifo_state_t st;
  fifo_state_t next_st;

  // ---------------------------------------------------------------
  // flop storage; push when full and pop when empty are dropped
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (push && !full)
    begin
      next_st.mem[st.wr] = wdata;
      next_st.wr         = st.wr + 1'b1;
    end
    if (pop && !empty)
      next_st.rd = st.rd + 1'b1;
    next_st.cnt = st.cnt + (AW+1)'(push && !full) - (AW+1)'(pop && !empty);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign rdata = st.mem[st.rd];
  assign empty = (st.cnt == '0);
  assign full  = (st.cnt == (AW+1)'(DEPTH));
endmodule : serial_rx_fifo
`default_nettype wire

/* File: src/serial_rx.sv */
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module serial_rx #(
  parameter int FIFO_DEPTH = 2  // buffered characters
)
(
  input  wire logic        clock,          // 125 MHz peripheral clock
  input  wire logic        rst,            // synchronous, active high
  input  wire logic        ce,             // freezes all state when low
  input  wire logic        baud_tick,      // sixteen pulses per bit
  input  wire logic [3:0]  addr,           // register index
  input  wire logic [15:0] wdata,          // write data
  input  wire logic        wr,             // write strobe
  input  wire logic        rd,             // read strobe
  output logic      [15:0] rdata,          // read data, cycle after rd
  input  wire logic        receive_pin,    // asynchronous serial line
  output logic             transmit_pin_oe,// transmit pin output enable
  output logic             receive_flag,   // unread character present
  output logic             rx_irq          // gated receive interrupt
);
  import serial_rx_pkg::*;

  initial
  begin
    if (FIFO_DEPTH != 2)
      $error("serial_rx: status path serves a two-entry fifo only");
  end

  typedef struct packed {
    logic [CTL_WIDTH-1:0] ctl;
    rx_state_t            state;
    logic [3:0]           tick;
    logic [3:0]           nbits;
    logic [1:0]           votes;
    logic [8:0]           receive_shift_register;
    logic                 overrun_flag;
    logic [15:0]          rdata;
    logic                 flag;
    logic                 irq;
    logic                 tx_oe;
    logic                 line_prev;
    logic                 stop_low;
  } rx_top_state_t;
  rx_top_state_t st;
  rx_top_state_t next_st;

  // -------------------------------------------------------------------
  // line input: synchroniser then polarity
  // -------------------------------------------------------------------
  logic pin_sync;
  logic line;
  serial_rx_sync u_sync (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .din   (receive_pin),
    .dout  (pin_sync)
  );
  assign line = pin_sync ^ st.ctl[CTL_POLARITY];

  // -------------------------------------------------------------------
  // receive buffer with a framing bit per entry
  // -------------------------------------------------------------------
  logic       push;
  logic       pop;
  logic [9:0] push_data;
  logic [9:0] head;
  logic       empty;
  logic       full;
  logic       port_en;
  logic       rx_en;
  logic       async_ok;
  logic       frame_done;
  logic       keep_char;
  logic       stop_bad;
  logic       bit_vote;

  assign port_en  = st.ctl[CTL_PORT_EN];
  assign rx_en    = st.ctl[CTL_RX_EN];
  assign async_ok = port_en && rx_en && !st.ctl[CTL_SYNC_MODE];

  serial_rx_fifo #(
    .WIDTH (10),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock (clock),
    .rst   (rst || !port_en),  // port disable flushes fifo and framing
    .ce    (ce),
    .push  (push),
    .wdata (push_data),
    .pop   (pop),
    .rdata (head),
    .empty (empty),
    .full  (full)
  );

  // majority of three samples around the bit centre
  assign bit_vote = (st.votes[1] & st.votes[0]) | (st.votes[1] & line) | (st.votes[0] & line);
  // stop level latched at its centre, so a following start bit cannot mask it
  assign stop_bad = st.stop_low;
  assign frame_done = baud_tick && (st.state == RX_STOP) && (st.tick == TICKS_PER_BIT);
  // address detect drops characters whose ninth bit is clear
  assign keep_char = !(st.ctl[CTL_ADDR_DET] && st.ctl[CTL_NINE_BIT] && !st.receive_shift_register[8]);
  assign push      = frame_done && keep_char && !full && !st.overrun_flag;
  assign push_data = {stop_bad, st.receive_shift_register};  // framing bit stored per entry
  assign pop       = rd && (addr == ADDR_DATA) && !empty;

  // -------------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------------
  always_comb
  begin
    next_st           = st;
    // edge reference is one baud tick old, so an edge between ticks is not missed
    if (baud_tick)
      next_st.line_prev = line;
    next_st.tx_oe     = port_en;  // transmit pin forced output

    // register writes
    if (wr && addr == ADDR_CONTROL)
      next_st.ctl = wdata[CTL_WIDTH-1:0];

    // receiver sequencer; ticks are the x16 enable
    if (!async_ok || st.overrun_flag)
    begin
      next_st.state = RX_IDLE;  // overrun blocks reception
      next_st.tick  = '0;
    end
    else if (baud_tick)
    begin
      next_st.tick = st.tick + 4'h1;
      if (st.tick == VOTE_FIRST)
        next_st.votes[1] = line;
      if (st.tick == VOTE_FIRST + 4'h1)
        next_st.votes[0] = line;
      unique case (st.state)
        RX_IDLE:
        begin
          next_st.tick = '0;
          if (!line && st.line_prev)
            next_st.state = RX_START;  // falling edge seen
        end
        RX_START:
        begin
          if (st.tick == TICKS_HALF_BIT)
          begin
            if (line)
              next_st.state = RX_IDLE;  // false start, silently dropped
          end
          if (st.tick == TICKS_PER_BIT)
          begin
            next_st.state = RX_DATA;
            next_st.nbits = '0;
          end
        end
        RX_DATA:
        begin
          if (st.tick == VOTE_LAST)
          begin
            // lsb first, one shift per bit
            if (st.ctl[CTL_NINE_BIT])
              next_st.receive_shift_register = {bit_vote, st.receive_shift_register[8:1]};
            else
              next_st.receive_shift_register = {1'b0, bit_vote, st.receive_shift_register[7:1]};
          end
          if (st.tick == TICKS_PER_BIT)
          begin
            next_st.nbits = st.nbits + 4'h1;
            if (st.nbits == (st.ctl[CTL_NINE_BIT] ? 4'h8 : 4'h7))
              next_st.state = RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (st.tick == VOTE_LAST)
            next_st.stop_low = !bit_vote;  // low stop marks framing error
          if (st.tick == TICKS_PER_BIT)
            next_st.state = RX_IDLE;  // framing error never halts
        end
      endcase
    end

    // third character with fifo full
    if (frame_done && keep_char && full && async_ok)
      next_st.overrun_flag = 1'b1;
    if (!rx_en || !port_en)
      next_st.overrun_flag = 1'b0;

    // flag and interrupt, framing alone raises nothing
    // two entries: popping while not full leaves the fifo empty
    next_st.flag = rx_en && port_en && (push || (!empty && !(pop && !full)));
    next_st.irq  = next_st.flag && st.ctl[CTL_RX_IE] && st.ctl[CTL_PERIPH_IE] && st.ctl[CTL_GLOBAL_IE];

    // read data, valid only in the cycle after rd
    next_st.rdata = '0;
    if (rd)
    begin
      unique case (addr)
        ADDR_CONTROL: next_st.rdata = 16'(st.ctl);
        ADDR_STATUS:
        begin
          next_st.rdata[STA_NINTH]   = !empty && head[8];
          next_st.rdata[STA_FRAMING] = !empty && head[9];  // oldest entry
          next_st.rdata[STA_OVERRUN] = st.overrun_flag;
          next_st.rdata[STA_FLAG]    = st.flag;
          next_st.rdata[STA_IDLE]    = (st.state == RX_IDLE);
        end
        ADDR_DATA:    next_st.rdata = {8'h00, head[7:0]};
        default:      next_st.rdata = '0;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st           <= '0;
      st.ctl       <= CTL_RESET;
      st.state     <= RX_IDLE;
      st.line_prev <= 1'b1;
    end
    else if (ce)
      st <= next_st;
  end

  assign rdata           = st.rdata;
  assign transmit_pin_oe = st.tx_oe;
  assign receive_flag    = st.flag;
  assign rx_irq          = st.irq;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  property p_flag_tracks;
    @(posedge clock) disable iff (rst)
      ce |=> (receive_flag == ($past(rx_en && port_en) && !empty));
  endproperty
  a_flag_tracks: assert property (p_flag_tracks) else $error("receive flag wrong");

  property p_irq_gate;
    @(posedge clock) disable iff (rst)
      rx_irq |-> receive_flag && $past(st.ctl[CTL_RX_IE] && st.ctl[CTL_PERIPH_IE] && st.ctl[CTL_GLOBAL_IE])
                 || !$past(ce);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enables");

  property p_tx_oe;
    @(posedge clock) disable iff (rst)
      ce && port_en |=> transmit_pin_oe;
  endproperty
  a_tx_oe: assert property (p_tx_oe) else $error("transmit pin not driven");

  property p_no_push_overrun;
    @(posedge clock) disable iff (rst)
      st.overrun_flag |-> !push;
  endproperty
  a_no_push_overrun: assert property (p_no_push_overrun) else $error("push during overrun");

  property p_overrun_clear;
    @(posedge clock) disable iff (rst)
      ce && !rx_en |=> !st.overrun_flag;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared");

  sequence s_false_start;
    baud_tick && st.state == RX_START && st.tick == TICKS_HALF_BIT && line && async_ok && ce;
  endsequence
  property p_false_start;
    @(posedge clock) disable iff (rst)
      s_false_start |=> st.state == RX_IDLE && !st.overrun_flag;
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start not dropped");

  property p_addr_drop;
    @(posedge clock) disable iff (rst)
      frame_done && st.ctl[CTL_ADDR_DET] && st.ctl[CTL_NINE_BIT] && !st.receive_shift_register[8] |-> !push;
  endproperty
  a_addr_drop: assert property (p_addr_drop) else $error("address filter failed");

  property p_pop_read;
    @(posedge clock) disable iff (rst)
      ce && pop |=> rdata[7:0] == $past(head[7:0]);
  endproperty
  a_pop_read: assert property (p_pop_read) else $error("read data not oldest");

  property p_rdata_quiet;
    @(posedge clock) disable iff (rst)
      ce && !rd |=> rdata == '0;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside read cycle");

  property p_port_flush;
    @(posedge clock) disable iff (rst)
      ce && !port_en |=> empty && !receive_flag;
  endproperty
  a_port_flush: assert property (p_port_flush) else $error("port disable kept entries");

  sequence s_third_char;
    ce && frame_done && keep_char && full && async_ok;
  endsequence
  property p_overrun_set;
    @(posedge clock) disable iff (rst)
      s_third_char |=> st.overrun_flag;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not raised");

  sequence s_stop_centre;
    ce && baud_tick && async_ok && !st.overrun_flag && st.state == RX_STOP && st.tick == VOTE_LAST;
  endsequence
  property p_stop_sample;
    @(posedge clock) disable iff (rst)
      s_stop_centre |=> st.stop_low == !$past(bit_vote);
  endproperty
  a_stop_sample: assert property (p_stop_sample) else $error("stop level not latched");

endmodule : serial_rx
`default_nettype wire

/* File: tb/serial_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model
(
  input  wire logic clock,      // peripheral clock
  input  wire logic baud_tick,  // x16 enable shared with receiver
  output var  logic line        // serial line into receiver
);
  initial line = 1'b1;

  // receive pin is a pure input of the receiver; only this model drives it

  // ---------------------------------------------
  // line drive
  // ---------------------------------------------
  // hold a level for so many x16 ticks
  task automatic hold(input logic level, input int ticks);
    line <= level;
    repeat (ticks)
    begin
      @(posedge clock);
      while (baud_tick !== 1'b1) @(posedge clock);
    end
  endtask : hold

  // idle level between frames, never left floating
  task automatic idle(input logic inv);
    line <= ~inv;
  endtask : idle

  // one frame, lsb first, sixteen ticks a bit
  task automatic send(input logic [8:0] d, input int nbits, input logic stop, input logic inv);
    hold(inv, 16);  // start bit
    for (int i = 0; i < nbits; i++) hold(d[i] ^ inv, 16);  // data bits
    hold(stop ^ inv, 16);  // low stop forces framing error
    hold(~inv, 2);  // idle gap so the next start is a real falling edge
  endtask : send

  // short low pulse, too brief to pass mid-start check
  task automatic glitch(input int ticks);
    hold(1'b0, ticks);
    line <= 1'b1;
  endtask : glitch
endmodule : serial_tx_model
`default_nettype wire

/* File: tb/async_serial_receiver_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module async_serial_receiver_bench;
  import serial_rx_pkg::*;
  localparam logic [15:0] EN = 16'(1 << CTL_PORT_EN | 1 << CTL_RX_EN);
  localparam logic [15:0] IE = 16'(1 << CTL_RX_IE | 1 << CTL_PERIPH_IE | 1 << CTL_GLOBAL_IE);
  localparam logic [15:0] N9 = 16'(1 << CTL_NINE_BIT);
  localparam logic [15:0] AD = 16'(1 << CTL_ADDR_DET);
  localparam logic [15:0] PL = 16'(1 << CTL_POLARITY);
  localparam int          LIMIT = 40000;  // over five times the expected run

  logic        clock, rst, ce, baud_tick, wr, rd, line, oe, flag, irq;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata;
  logic [1:0]  tick_div;
  int          cycles, fail_count, samples_checked;

  serial_rx #(.FIFO_DEPTH(2)) uut (.clock(clock), .rst(rst), .ce(ce), .baud_tick(baud_tick),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .receive_pin(line),
    .transmit_pin_oe(oe), .receive_flag(flag), .rx_irq(irq));
  serial_tx_model tx (.clock(clock), .baud_tick(baud_tick), .line(line));

  always #4 clock = ~clock;

  // ---------------------------------------------
  // x16 tick every fourth cycle, and hang guard
  // ---------------------------------------------
  always @(posedge clock)
  begin
    tick_div <= tick_div + 2'd1;
    baud_tick <= (tick_div == 2'd3);
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t timeout", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // ---------------------------------------------
  // register port: one-cycle strobes
  // ---------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task automatic st(input int idx, input logic exp);
    logic [15:0] v;
    rd_reg(ADDR_STATUS, v);
    chk(16'(v[idx]), 16'(exp));
  endtask : st

  task automatic data(input logic [7:0] exp);
    logic [15:0] v;
    rd_reg(ADDR_DATA, v);
    chk(16'(v[7:0]), 16'(exp));
  endtask : data

  // bounded wait; push lands on the last stop tick
  task automatic wait_flag();
    for (int n = 0; n < 300 && flag !== 1'b1; n++) @(posedge clock);
    chk(16'(flag), 16'h0001);
  endtask : wait_flag

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic test_reset();
    logic [15:0] v;
    rd_reg(ADDR_CONTROL, v);
    chk(v, 16'(CTL_RESET));
    rd_reg(4'h5, v);
    chk(v, 16'h0000);
    chk({14'h0, oe, irq}, 16'h0000);
    wr_reg(ADDR_CONTROL, EN);
    @(posedge clock);
    #1 chk(16'(oe), 16'h0001);
    // a write while the clock enable is low must be dropped
    @(posedge clock);
    ce <= 1'b0;
    wr_reg(ADDR_CONTROL, 16'h0000);
    ce <= 1'b1;
    rd_reg(ADDR_CONTROL, v);
    chk(v, EN);
    chk(16'(oe), 16'h0001);
    $display("reset test done");
  endtask : test_reset

  task automatic test_basic();
    tx.send(9'h0A5, 8, 1'b1, 1'b0);
    wait_flag();
    st(STA_FRAMING, 1'b0);
    data(8'hA5);
    @(posedge clock);
    #1 chk(16'(flag), 16'h0000);
    $display("basic test done");
  endtask : test_basic

  task automatic test_glitch();
    tx.glitch(4);
    repeat (150) @(posedge clock);
    chk(16'(flag), 16'h0000);
    tx.send(9'h096, 8, 1'b1, 1'b0);
    wait_flag();
    data(8'h96);
    $display("glitch test done");
  endtask : test_glitch

  task automatic test_errors();
    tx.send(9'h03C, 8, 1'b0, 1'b0);
    tx.send(9'h05A, 8, 1'b0, 1'b0);
    wait_flag();
    chk(16'(irq), 16'h0000);
    st(STA_OVERRUN, 1'b0);
    tx.send(9'h011, 8, 1'b1, 1'b0);
    st(STA_OVERRUN, 1'b1);
    st(STA_FRAMING, 1'b1);
    wr_reg(ADDR_CONTROL, EN | IE);
    repeat (2) @(posedge clock);
    #1 chk(16'(irq), 16'h0001);
    data(8'h3C);
    st(STA_FRAMING, 1'b1);
    data(8'h5A);
    repeat (2) @(posedge clock);
    #1 chk({14'h0, flag, irq}, 16'h0000);
    st(STA_OVERRUN, 1'b1);
    wr_reg(ADDR_CONTROL, 16'(1 << CTL_PORT_EN));
    st(STA_OVERRUN, 1'b0);
    $display("error test done");
  endtask : test_errors

  task automatic test_port_off();
    wr_reg(ADDR_CONTROL, EN);
    tx.send(9'h077, 8, 1'b0, 1'b0);
    wait_flag();
    wr_reg(ADDR_CONTROL, 16'(1 << CTL_PORT_EN));
    @(posedge clock);
    #1 chk(16'(flag), 16'h0000);
    st(STA_FRAMING, 1'b1);
    wr_reg(ADDR_CONTROL, 16'h0000);
    st(STA_FRAMING, 1'b0);
    chk(16'(oe), 16'h0000);
    $display("port off test done");
  endtask : test_port_off

  task automatic test_polarity();
    tx.idle(1'b1);
    repeat (8) @(posedge clock);
    wr_reg(ADDR_CONTROL, EN | PL);
    repeat (8) @(posedge clock);
    tx.send(9'h0C3, 8, 1'b1, 1'b1);
    wait_flag();
    data(8'hC3);
    wr_reg(ADDR_CONTROL, 16'h0000);
    tx.idle(1'b0);
    $display("polarity test done");
  endtask : test_polarity

  task automatic test_address();
    wr_reg(ADDR_CONTROL, EN | N9 | AD);
    tx.send(9'h0AA, 9, 1'b1, 1'b0);
    repeat (20) @(posedge clock);
    chk(16'(flag), 16'h0000);
    tx.send(9'h155, 9, 1'b1, 1'b0);
    wait_flag();
    st(STA_NINTH, 1'b1);
    data(8'h55);
    wr_reg(ADDR_CONTROL, EN | N9);
    tx.send(9'h0AA, 9, 1'b1, 1'b0);
    wait_flag();
    st(STA_NINTH, 1'b0);
    data(8'hAA);
    $display("address test done");
  endtask : test_address

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    baud_tick = 1'b0;
    tick_div = 2'd0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    cycles = 0;
    fail_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    test_reset();
    test_basic();
    test_glitch();
    test_errors();
    test_port_off();
    test_polarity();
    test_address();
    finish_test();
  end
endmodule : async_serial_receiver_bench
`default_nettype wire
